// ---- bench/css_osc_model.sv ----
// css_osc_model: oscillator pins and ready levels seen by the start-up block
// assumes a 4 ns system clock; every pin toggles slower than half of it
`timescale 1ns/1ps
`default_nettype none
module css_osc_model (
  // control
  input wire logic xtal,
  input wire logic inv_en,
  input wire logic fast_go,
  // oscillator pins
  output logic pri,
  output logic sec,
  output logic intc,
  output logic lf,
  // ready levels
  output logic fast_rdy,
  output logic rdy
);
  initial
  begin
    pri = 1'b0;
    sec = 1'b0;
    intc = 1'b0;
    lf = 1'b0;
  end
  // a crystal rests at its quiescent level without the inverter
  always #20 pri = (!xtal || inv_en) ? !pri : 1'b0;
  always #40 sec = !sec;
  always #12 intc = !intc;
  always #10 lf = !lf;
  assign fast_rdy = fast_go;
  assign rdy = 1'b1;
endmodule : css_osc_model
`default_nettype wire

// ---- bench/css_startup_ctrl_sva.sv ----
// css_startup_ctrl_sva: port-level checks of the start-up and switch block
// assumes config bits stay steady outside reset
`timescale 1ns/1ps
`default_nettype none
module css_startup_ctrl_sva
  import css_pkg::*;
(
  // clock, reset, inputs
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [3:0] PRIMARY_OSC_CONFIG,
  input wire logic CTRL_WRITE,
  input wire logic [1:0] CTRL_SOURCE_SELECT,
  input wire logic [2:0] CTRL_FREQ_SELECT,
  input wire logic SLEEP_REQ,
  input wire logic FAST_INT_READY,
  // outputs
  input wire logic DEVICE_RESET,
  input wire logic [1:0] CLOCK_SOURCE_SELECT,
  input wire logic [2:0] INTERNAL_FREQ_SELECT,
  input wire logic STARTUP_TIMEOUT_FLAG,
  input wire logic FAST_INTERNAL_STABLE,
  input wire logic QUARTER_CLOCK_OUTPUT,
  input wire logic QUARTER_CLOCK_OE,
  input wire logic FEEDBACK_INVERTER_EN
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  chk_rel_select: assert property ($fell(SYS_RST) |->
    CLOCK_SOURCE_SELECT == SEL_RESET && INTERNAL_FREQ_SELECT == FREQ_RESET)
    else $error("select not cleared by reset");
  chk_rel_held: assert property ($fell(SYS_RST) |-> DEVICE_RESET && !STARTUP_TIMEOUT_FLAG)
    else $error("device not held at reset release");
  chk_write_load: assert property (CTRL_WRITE |=>
    CLOCK_SOURCE_SELECT == $past(CTRL_SOURCE_SELECT)
    && INTERNAL_FREQ_SELECT == $past(CTRL_FREQ_SELECT))
    else $error("control write not loaded");
  chk_select_hold: assert property (!CTRL_WRITE |=> $stable(CLOCK_SOURCE_SELECT))
    else $error("source select changed without write");
  chk_sleep_inv: assert property (SLEEP_REQ && STARTUP_TIMEOUT_FLAG |->
    ##[1:4] !FEEDBACK_INVERTER_EN && !QUARTER_CLOCK_OUTPUT)
    else $error("sleep left inverter or quarter clock on");
  chk_sleep_flag: assert property (SLEEP_REQ && STARTUP_TIMEOUT_FLAG |->
    ##[1:4] !STARTUP_TIMEOUT_FLAG)
    else $error("timeout flag kept in sleep");
  chk_flag_ext: assert property ($rose(STARTUP_TIMEOUT_FLAG) |-> !PRIMARY_OSC_CONFIG[3])
    else $error("timeout flag in internal mode");
  chk_fast_up: assert property (FAST_INT_READY [*5] |-> FAST_INTERNAL_STABLE)
    else $error("fast stable flag missing");
  chk_fast_down: assert property (!FAST_INT_READY [*5] |-> !FAST_INTERNAL_STABLE)
    else $error("fast stable flag stuck");
  chk_quarter_oe: assert property (!DEVICE_RESET |->
    QUARTER_CLOCK_OE == (PRIMARY_OSC_CONFIG inside {4'h5, 4'h7, 4'h9}))
    else $error("quarter clock enable wrong");
endmodule : css_startup_ctrl_sva
bind css_startup_ctrl css_startup_ctrl_sva chk (.CLK(CLK), .SYS_RST(SYS_RST),
  .PRIMARY_OSC_CONFIG(PRIMARY_OSC_CONFIG), .CTRL_WRITE(CTRL_WRITE),
  .CTRL_SOURCE_SELECT(CTRL_SOURCE_SELECT), .CTRL_FREQ_SELECT(CTRL_FREQ_SELECT),
  .SLEEP_REQ(SLEEP_REQ), .FAST_INT_READY(FAST_INT_READY), .DEVICE_RESET(DEVICE_RESET),
  .CLOCK_SOURCE_SELECT(CLOCK_SOURCE_SELECT), .INTERNAL_FREQ_SELECT(INTERNAL_FREQ_SELECT),
  .STARTUP_TIMEOUT_FLAG(STARTUP_TIMEOUT_FLAG), .FAST_INTERNAL_STABLE(FAST_INTERNAL_STABLE),
  .QUARTER_CLOCK_OUTPUT(QUARTER_CLOCK_OUTPUT), .QUARTER_CLOCK_OE(QUARTER_CLOCK_OE),
  .FEEDBACK_INVERTER_EN(FEEDBACK_INVERTER_EN));
`default_nettype wire

// ---- bench/css_startup_ctrl_tb.sv ----
// css_startup_ctrl_tb: directed start-up, switch and sleep sequences
// assumes the oscillator model runs free; multiplier lock shortened to 16
`timescale 1ns/1ps
`default_nettype none
module css_startup_ctrl_tb
  import css_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, pd_n = 1'b1, ts = 1'b0, fs = 1'b1, pll = 1'b0;
  logic wr = 1'b0, slp = 1'b0, wake = 1'b0, fast_go = 1'b1;
  logic [3:0] cfg = 4'h2;
  logic [1:0] src = 2'h0;
  logic [2:0] frq = 3'h3;
  logic pri, sec, intc, lf, frdy, rdy, sclk, dres, csr, busy, med, low, flag, fst, mst, lst, srun;
  logic qout, qoe, finv;
  logic [1:0] sel;
  logic [2:0] fsel;
  int n_fail = 0, n_tests = 0, cycles = 0, pri_n = 0, lf_n = 0, hi = 0;
  always #2 clk = !clk;
  always @(posedge pri) pri_n++;
  always @(posedge lf) lf_n++;
  css_osc_model osc (.xtal(!cfg[3] && !cfg[2]), .inv_en(finv), .fast_go(fast_go), .pri(pri),
    .sec(sec), .intc(intc), .lf(lf), .fast_rdy(frdy), .rdy(rdy));
  css_startup_ctrl #(.PLL_LOCK_COUNT(16)) dut (.CLK(clk), .SYS_RST(rst),
    .POWER_UP_DELAY_ENABLE_N(pd_n), .PRIMARY_OSC_CONFIG(cfg), .TWO_SPEED_ENABLE(ts),
    .FAST_START_IMMEDIATE(fs), .PLL_ENABLE(pll), .CTRL_WRITE(wr), .CTRL_SOURCE_SELECT(src),
    .CTRL_FREQ_SELECT(frq), .CTRL_MEDIUM_SELECT(1'b0), .CTRL_LOW_FREQ_SELECT(1'b0),
    .SLEEP_REQ(slp), .WAKE_REQ(wake), .PRI_OSC_IN(pri), .SEC_OSC_IN(sec), .INT_OSC_IN(intc),
    .LF_INT_OSC_IN(lf), .FAST_INT_READY(frdy), .MED_INT_READY(rdy), .LOW_INT_READY(rdy),
    .SEC_OSC_READY(rdy), .SYS_CLK_OUT(sclk), .DEVICE_RESET(dres), .CODE_START_READY(csr),
    .SWITCH_BUSY(busy), .CLOCK_SOURCE_SELECT(sel), .INTERNAL_FREQ_SELECT(fsel),
    .MEDIUM_OSC_SELECT(med), .LOW_FREQ_SOURCE_SELECT(low), .STARTUP_TIMEOUT_FLAG(flag),
    .FAST_INTERNAL_STABLE(fst), .MEDIUM_INTERNAL_STABLE(mst), .LOW_INTERNAL_STABLE(lst),
    .SECONDARY_RUNNING(srun), .QUARTER_CLOCK_OUTPUT(qout), .QUARTER_CLOCK_OE(qoe),
    .FEEDBACK_INVERTER_EN(finv));
  always @(posedge clk) if (sclk === 1'b1) hi++;
  // ---------------------------------------------
  // shared tasks
  // ---------------------------------------------
  task automatic final_report();
    $display("Tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("Error t=%0t got %h exp %h", $time, got, exp);
      n_fail++;
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // wait for reset (0), busy (1) or missing flag (2) to clear
  task automatic wt(input int s, input int max);
    int k;
    k = 0;
    while ((s == 0 ? dres : s == 1 ? busy : !flag) !== 1'b0 && k < max)
    begin
      cyc(1);
      k++;
    end
    chk(k < max, 1);
  endtask : wt
  // config bits change only under reset, as they would from fuses
  task automatic boot(input logic [3:0] c, input logic t, p, l, f);
    @(posedge clk);
    rst <= 1'b1;
    cfg <= c;
    ts <= t;
    pd_n <= p;
    pll <= l;
    fs <= f;
    cyc(15);
    chk(dres, 1);
    chk({sel, fsel}, {SEL_RESET, FREQ_RESET});
    @(posedge clk);
    rst <= 1'b0;
    pri_n = 0;
    lf_n = 0;
  endtask : boot
  task automatic ctl(input logic [1:0] s, input logic [2:0] f);
    @(posedge clk);
    wr <= 1'b1;
    src <= s;
    frq <= f;
    @(posedge clk);
    wr <= 1'b0;
    cyc(0);
    chk({sel, fsel}, {s, f});
    cyc(2);
  endtask : ctl
  task automatic pulse_sleep(input logic w);
    @(posedge clk);
    if (w)
      wake <= 1'b1;
    else
      slp <= 1'b1;
    @(posedge clk);
    slp <= 1'b0;
    wake <= 1'b0;
  endtask : pulse_sleep
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      n_fail++;
      final_report();
    end
  end
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial
  begin
    boot(4'h2, 1'b0, 1'b1, 1'b0, 1'b1);
    wait (pri_n >= 1000);
    chk(dres, 1);
    wt(0, 3000);
    chk(pri_n >= 1024, 1);
    wt(2, 50);
    wt(1, 600);
    chk({med, low, mst, lst}, 4'h3);
    ctl(SEL_SECONDARY, 3'h3);
    wt(1, 600);
    // running flag is registered one cycle behind the switch going idle
    cyc(1);
    chk(srun, 1);
    ctl(SEL_INTERNAL, 3'h7);
    wt(1, 600);
    chk({srun, flag}, 2'h1);
    ctl(SEL_INTERNAL, 3'h6);
    chk(busy, 0);
    ctl(SEL_PRIMARY, 3'h6);
    wt(1, 600);
    pulse_sleep(1'b0);
    cyc(4);
    chk({finv, flag, qout, sclk}, 4'h0);
    pulse_sleep(1'b1);
    wt(2, 12000);
    boot(4'h0, 1'b1, 1'b1, 1'b0, 1'b1);
    wt(0, 200);
    chk({flag, sel}, 3'h0);
    pulse_sleep(1'b0);
    cyc(2000);
    chk(flag, 0);
    pulse_sleep(1'b1);
    wt(2, 12000);
    chk(sel, SEL_PRIMARY);
    boot(4'h4, 1'b0, 1'b0, 1'b0, 1'b1);
    wait (lf_n >= 2000);
    chk(dres, 1);
    wt(0, 2000);
    chk({lf_n >= 2048, qoe}, 2'h2);
    boot(4'h5, 1'b0, 1'b1, 1'b1, 1'b1);
    wt(0, 100);
    chk({qoe, csr}, 2'h3);
    fast_go <= 1'b0;
    boot(4'h8, 1'b0, 1'b1, 1'b0, 1'b0);
    cyc(40);
    hi = 0;
    cyc(40);
    chk({hi != 0, fst}, 2'h0);
    fast_go <= 1'b1;
    cyc(40);
    hi = 0;
    cyc(40);
    chk({hi != 0, fst}, 2'h3);
    fast_go <= 1'b0;
    boot(4'h8, 1'b0, 1'b1, 1'b0, 1'b1);
    cyc(40);
    hi = 0;
    cyc(40);
    chk({hi != 0, fst}, 2'h2);
    final_report();
  end
endmodule : css_startup_ctrl_tb
`default_nettype wire

// ---- rtl/css_clk_switch.sv ----
// css_clk_switch: glitch-free handover of the system clock between sources
// assumes source levels and edge pulses already synchronised to clk
`timescale 1ns/1ps
`default_nettype none
module css_clk_switch
  import css_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // source levels and edges, indexed by select code
  input wire logic [2:0] src_level,
  input wire logic [2:0] src_rise,
  input wire logic [2:0] src_fall,
  // request
  input wire logic [1:0] target,
  input wire logic target_ready,
  input wire logic halt,
  // result
  output logic sys_clk,
  output logic sys_rise,
  output logic [1:0] cur_src,
  output logic busy
);
  css_sw_t state;
  css_sw_t next_state;
  logic cnt;
  logic next_cnt;
  logic next_sys_clk;

  function automatic logic pick(input logic [2:0] v, input logic [1:0] i);
    pick = (i == 2'h3) ? 1'b0 : v[i];
  endfunction : pick

  wire old_rise = pick(src_rise, cur_src);
  wire old_fall = pick(src_fall, cur_src);
  wire new_rise = pick(src_rise, target);
  wire new_fall = pick(src_fall, target);
  wire holding = (state == SW_NEW_RISE) || (state == SW_NEW_FALL);
  wire release_now = (state == SW_NEW_FALL) && new_fall;

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      SW_IDLE:
        if (target != cur_src)
          next_state = SW_READY;
      // old clock keeps running while the new one starts
      SW_READY:
        if (target == cur_src)
          next_state = SW_IDLE;
        else if (target_ready)
        begin
          next_state = SW_OLD_RISE;
          next_cnt = 1'b0;
        end
      SW_OLD_RISE:
        if (old_rise)
        begin
          next_cnt = 1'b1;
          if (cnt)
            next_state = SW_OLD_FALL;
        end
      SW_OLD_FALL:
        if (old_fall)
        begin
          next_state = SW_NEW_RISE;
          next_cnt = 1'b0;
        end
      SW_NEW_RISE:
        if (new_rise)
        begin
          next_cnt = 1'b1;
          if (cnt)
            next_state = SW_NEW_FALL;
        end
      SW_NEW_FALL:
        if (new_fall)
          next_state = SW_IDLE;
      default:
        next_state = SW_IDLE;
    endcase
  end

  // low hold spans only the new source's edge counts
  assign next_sys_clk = ~halt & ~holding & pick(src_level, cur_src);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= SW_IDLE;
      cnt <= 1'b0;
      cur_src <= SEL_RESET;
      sys_clk <= 1'b0;
      sys_rise <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      if (release_now)
        cur_src <= target;
      sys_clk <= next_sys_clk;
      sys_rise <= next_sys_clk & ~sys_clk;
    end
  end

  assign busy = (state != SW_IDLE);
endmodule : css_clk_switch
`default_nettype wire

// ---- rtl/css_pin_sync.sv ----
// css_pin_sync: two-stage synchroniser for one pin, with edge pulses
// assumes the pin toggles slower than half the system clock
`timescale 1ns/1ps
`default_nettype none
module css_pin_sync
  import css_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pin and its synchronised forms
  input wire logic pin_in,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta;
  logic stable;
  logic prev;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta <= 1'b0;
      stable <= 1'b0;
      prev <= 1'b0;
    end
    else
    begin
      meta <= pin_in;
      stable <= meta;
      prev <= stable;
    end
  end

  assign level = stable;
  assign rise = stable & ~prev;
  assign fall = ~stable & prev;
endmodule : css_pin_sync
`default_nettype wire

// ---- rtl/css_pkg.sv ----
// css_pkg: constants and state types for the clock switch and start-up control
// assumes one 250 MHz system clock; oscillator inputs are asynchronous pins
package css_pkg;

  localparam int CLK_MHZ = 250;

  // primary oscillator configuration codes
  localparam logic [3:0] PRI_LOW_POWER_CRYSTAL = 4'h0;
  localparam logic [3:0] PRI_CRYSTAL_MEDIUM = 4'h1;
  localparam logic [3:0] PRI_HIGH_SPEED_CRYSTAL = 4'h2;
  localparam logic [3:0] PRI_EXTERNAL_CLOCK_INPUT_IO = 4'h4;
  localparam logic [3:0] PRI_EXTERNAL_CLOCK_INPUT_QUARTER_CLOCK_OUTPUT = 4'h5;
  localparam logic [3:0] PRI_RESISTOR_CAPACITOR_OSC_IO = 4'h6;
  localparam logic [3:0] PRI_RESISTOR_CAPACITOR_OSC_QUARTER_CLOCK_OUTPUT = 4'h7;
  localparam logic [3:0] PRI_INTERNAL_OSC_MODE_IO = 4'h8;
  localparam logic [3:0] PRI_INTERNAL_OSC_MODE_QUARTER_CLOCK_OUTPUT = 4'h9;

  // clock source select codes, also the switch source index
  localparam logic [1:0] SEL_PRIMARY = 2'h0;
  localparam logic [1:0] SEL_SECONDARY = 2'h1;
  localparam logic [1:0] SEL_INTERNAL = 2'h2;

  // values after reset
  localparam logic [1:0] SEL_RESET = 2'h0;
  localparam logic [2:0] FREQ_RESET = 3'h3;

  // start-up counts
  localparam int OST_CYCLES = 1024;
  localparam int PLL_LOCK_TIME_US = 2000;
  localparam int PLL_LOCK_CYCLES = PLL_LOCK_TIME_US * CLK_MHZ;
  localparam int POWER_UP_DELAY_TIMER_LF_CYCLES = 2048;
  localparam int CODE_START_LF_CYCLES = 4;
  localparam int SEQ_CNT_W = 20;
  localparam int CSD_CNT_W = 4;

  // synchronised pin indices
  localparam int PIN_PRI = 0;
  localparam int PIN_SEC = 1;
  localparam int PIN_INT = 2;
  localparam int PIN_LF = 3;
  localparam int PIN_FAST_RDY = 4;
  localparam int PIN_MED_RDY = 5;
  localparam int PIN_LOW_RDY = 6;
  localparam int PIN_SEC_RDY = 7;
  localparam int PIN_COUNT = 8;

  typedef enum logic [2:0] {
    SEQ_POR = 3'b000, SEQ_POWER_UP_DELAY_TIMER = 3'b001, SEQ_OST = 3'b010,
    SEQ_PLL = 3'b011, SEQ_RUN = 3'b100, SEQ_SLEEP = 3'b101
  } css_seq_t;

  typedef enum logic [2:0] {
    SW_IDLE = 3'b000, SW_READY = 3'b001, SW_OLD_RISE = 3'b010,
    SW_OLD_FALL = 3'b011, SW_NEW_RISE = 3'b100, SW_NEW_FALL = 3'b101
  } css_sw_t;

endpackage : css_pkg

// ---- rtl/css_startup_ctrl.sv ----
// css_startup_ctrl: reset timers, two-speed start-up and clock source switching
// assumes oscillator and ready pins asynchronous; config bits stable out of reset
`timescale 1ns/1ps
`default_nettype none
module css_startup_ctrl
  import css_pkg::*;
#(
  parameter int PLL_LOCK_COUNT = PLL_LOCK_CYCLES
)
(
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // configuration bits
  input wire logic POWER_UP_DELAY_ENABLE_N,
  input wire logic [3:0] PRIMARY_OSC_CONFIG,
  input wire logic TWO_SPEED_ENABLE,
  input wire logic FAST_START_IMMEDIATE,
  input wire logic PLL_ENABLE,
  // software control write
  input wire logic CTRL_WRITE,
  input wire logic [1:0] CTRL_SOURCE_SELECT,
  input wire logic [2:0] CTRL_FREQ_SELECT,
  input wire logic CTRL_MEDIUM_SELECT,
  input wire logic CTRL_LOW_FREQ_SELECT,
  // power management events
  input wire logic SLEEP_REQ,
  input wire logic WAKE_REQ,
  // oscillator pins and readiness
  input wire logic PRI_OSC_IN,
  input wire logic SEC_OSC_IN,
  input wire logic INT_OSC_IN,
  input wire logic LF_INT_OSC_IN,
  input wire logic FAST_INT_READY,
  input wire logic MED_INT_READY,
  input wire logic LOW_INT_READY,
  input wire logic SEC_OSC_READY,
  // system clock and reset
  output logic SYS_CLK_OUT,
  output logic DEVICE_RESET,
  output logic CODE_START_READY,
  output logic SWITCH_BUSY,
  // settings to the internal oscillator block
  output logic [1:0] CLOCK_SOURCE_SELECT,
  output logic [2:0] INTERNAL_FREQ_SELECT,
  output logic MEDIUM_OSC_SELECT,
  output logic LOW_FREQ_SOURCE_SELECT,
  // status
  output logic STARTUP_TIMEOUT_FLAG,
  output logic FAST_INTERNAL_STABLE,
  output logic MEDIUM_INTERNAL_STABLE,
  output logic LOW_INTERNAL_STABLE,
  output logic SECONDARY_RUNNING,
  // oscillator pins in sleep
  output logic QUARTER_CLOCK_OUTPUT,
  output logic QUARTER_CLOCK_OE,
  output logic FEEDBACK_INVERTER_EN
);

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  function automatic logic is_crystal(input logic [3:0] c);
    is_crystal = (c == PRI_LOW_POWER_CRYSTAL) || (c == PRI_CRYSTAL_MEDIUM) ||
                 (c == PRI_HIGH_SPEED_CRYSTAL);
  endfunction : is_crystal

  function automatic logic is_internal(input logic [3:0] c);
    is_internal = (c == PRI_INTERNAL_OSC_MODE_IO) || (c == PRI_INTERNAL_OSC_MODE_QUARTER_CLOCK_OUTPUT);
  endfunction : is_internal

  function automatic logic has_quarter_clock_output(input logic [3:0] c);
    has_quarter_clock_output = (c == PRI_EXTERNAL_CLOCK_INPUT_QUARTER_CLOCK_OUTPUT) ||
                 (c == PRI_RESISTOR_CAPACITOR_OSC_QUARTER_CLOCK_OUTPUT) ||
                 (c == PRI_INTERNAL_OSC_MODE_QUARTER_CLOCK_OUTPUT);
  endfunction : has_quarter_clock_output

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  wire [PIN_COUNT-1:0] pins = {SEC_OSC_READY, LOW_INT_READY, MED_INT_READY, FAST_INT_READY,
                               LF_INT_OSC_IN, INT_OSC_IN, SEC_OSC_IN, PRI_OSC_IN};
  logic [PIN_COUNT-1:0] pin_lvl;
  logic [PIN_COUNT-1:0] pin_rise;
  logic [PIN_COUNT-1:0] pin_fall;

  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++)
    begin : g_sync
      css_pin_sync u_sync (
        .clk(CLK),
        .rst(SYS_RST),
        .pin_in(pins[gi]),
        .level(pin_lvl[gi]),
        .rise(pin_rise[gi]),
        .fall(pin_fall[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // software control register
  // ------------------------------------------------------------
  logic [1:0] csel;
  logic [2:0] freq_sel;
  logic med_sel;
  logic lf_sel;

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      csel <= SEL_RESET;
      freq_sel <= FREQ_RESET;
      med_sel <= 1'b0;
      lf_sel <= 1'b0;
    end
    else if (CTRL_WRITE)
    begin
      csel <= CTRL_SOURCE_SELECT;
      freq_sel <= CTRL_FREQ_SELECT;
      med_sel <= CTRL_MEDIUM_SELECT;
      lf_sel <= CTRL_LOW_FREQ_SELECT;
    end
  end

  // ------------------------------------------------------------
  // start-up sequence
  // ------------------------------------------------------------
  css_seq_t seq;
  css_seq_t next_seq;
  logic [SEQ_CNT_W-1:0] seq_cnt;
  logic [CSD_CNT_W-1:0] csd_cnt;
  logic startup_timeout_flag;
  logic [1:0] target;
  logic target_ready;
  logic sys_clk;
  logic sys_rise;
  logic [1:0] cur_src;
  logic busy;
  logic [1:0] quarter_cnt;

  wire crystal = is_crystal(PRIMARY_OSC_CONFIG);
  wire internal_pri = is_internal(PRIMARY_OSC_CONFIG);
  wire external_pri = ~internal_pri;
  wire lf_tick = pin_rise[PIN_LF];
  wire pri_rise = pin_rise[PIN_PRI];
  wire power_up_delay_timer_on = (POWER_UP_DELAY_ENABLE_N == 1'b0);
  wire pll_on = PLL_ENABLE & external_pri;
  wire two_speed = TWO_SPEED_ENABLE & (csel == SEL_PRIMARY) & crystal;
  wire starting = (seq == SEQ_OST) || (seq == SEQ_PLL);
  // multiplier lock only follows the count when the multiplier is on
  wire [2:0] after_ost = pll_on ? SEQ_PLL : SEQ_RUN;
  wire power_up_delay_timer_done = lf_tick && (seq_cnt == SEQ_CNT_W'(POWER_UP_DELAY_TIMER_LF_CYCLES - 1));
  wire ost_done = pri_rise && (seq_cnt == SEQ_CNT_W'(OST_CYCLES - 1));
  wire pll_done = (seq_cnt == SEQ_CNT_W'(PLL_LOCK_COUNT - 1));
  // only code running from the internal clock can sleep mid start-up
  wire sleep_ok = (seq == SEQ_RUN) || (starting && two_speed);

  always_comb
  begin
    next_seq = seq;
    case (seq)
      SEQ_POR:
        next_seq = power_up_delay_timer_on ? SEQ_POWER_UP_DELAY_TIMER : SEQ_OST;
      SEQ_POWER_UP_DELAY_TIMER:
        if (power_up_delay_timer_done)
          next_seq = SEQ_OST;
      SEQ_OST:
        if (!crystal || ost_done)
          next_seq = css_seq_t'(after_ost);
      SEQ_PLL:
        if (pll_done)
          next_seq = SEQ_RUN;
      SEQ_RUN:
        next_seq = SEQ_RUN;
      // wake restarts start-up without power-up delay
      SEQ_SLEEP:
        if (WAKE_REQ)
          next_seq = SEQ_OST;
      default:
        next_seq = SEQ_POR;
    endcase
    if (SLEEP_REQ && sleep_ok)
      next_seq = SEQ_SLEEP;
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      seq <= SEQ_POR;
      seq_cnt <= '0;
    end
    else
    begin
      seq <= next_seq;
      if (next_seq != seq)
        seq_cnt <= '0;
      else if ((seq == SEQ_POWER_UP_DELAY_TIMER && lf_tick) || (seq == SEQ_OST && pri_rise) ||
               seq == SEQ_PLL)
        seq_cnt <= seq_cnt + 1'b1;
    end
  end

  // ------------------------------------------------------------
  // code-start delay and reset hold
  // ------------------------------------------------------------
  wire csd_done = (csd_cnt == CSD_CNT_W'(CODE_START_LF_CYCLES));
  // two-speed releases reset during the count
  wire hold_rst = (seq == SEQ_POR) || (seq == SEQ_POWER_UP_DELAY_TIMER) || (starting && !two_speed);

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      csd_cnt <= '0;
      DEVICE_RESET <= 1'b1;
      CODE_START_READY <= 1'b0;
    end
    else
    begin
      if (lf_tick && !csd_done)
        csd_cnt <= csd_cnt + 1'b1;
      CODE_START_READY <= csd_done;
      DEVICE_RESET <= hold_rst | ~csd_done;
    end
  end

  // ------------------------------------------------------------
  // start-up timeout flag
  // ------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      startup_timeout_flag <= 1'b0;
    else if (next_seq != SEQ_RUN)
      startup_timeout_flag <= 1'b0;
    // set once the sequence reaches run with an external primary, before the clock switches to it
    else if (external_pri)
      startup_timeout_flag <= 1'b1;
  end

  // ------------------------------------------------------------
  // source selection
  // ------------------------------------------------------------
  // primary, internal while two-speed waits
  // switch to external once the flag is set
  wire [1:0] sel_primary = (internal_pri || !startup_timeout_flag) ? SEL_INTERNAL : SEL_PRIMARY;
  assign target = (csel == SEL_PRIMARY) ? sel_primary :
                  (csel == SEL_SECONDARY) ? SEL_SECONDARY : SEL_INTERNAL;
  // slow selections use the low or medium source
  wire int_ready = (freq_sel == 3'h0 && !lf_sel) ? pin_lvl[PIN_LOW_RDY] :
                   (med_sel && freq_sel <= 3'h2) ? pin_lvl[PIN_MED_RDY] :
                   pin_lvl[PIN_FAST_RDY];
  assign target_ready = (target == SEL_PRIMARY) ? startup_timeout_flag :
                        (target == SEL_SECONDARY) ? pin_lvl[PIN_SEC_RDY] : int_ready;
  // hold clock until fast internal is stable unless fast start
  wire int_wait = internal_pri && (csel == SEL_PRIMARY) && !FAST_START_IMMEDIATE &&
                  !pin_lvl[PIN_FAST_RDY];
  wire halt = (seq == SEQ_SLEEP) || int_wait;

  // frequency code goes straight out, no handover
  css_clk_switch u_switch (
    .clk(CLK),
    .rst(SYS_RST),
    .src_level({pin_lvl[PIN_INT], pin_lvl[PIN_SEC], pin_lvl[PIN_PRI]}),
    .src_rise({pin_rise[PIN_INT], pin_rise[PIN_SEC], pin_rise[PIN_PRI]}),
    .src_fall({pin_fall[PIN_INT], pin_fall[PIN_SEC], pin_fall[PIN_PRI]}),
    .target(target),
    .target_ready(target_ready),
    .halt(halt),
    .sys_clk(sys_clk),
    .sys_rise(sys_rise),
    .cur_src(cur_src),
    .busy(busy)
  );

  // ------------------------------------------------------------
  // status and sleep pins
  // ------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      quarter_cnt <= 2'h0;
      QUARTER_CLOCK_OUTPUT <= 1'b0;
      QUARTER_CLOCK_OE <= 1'b0;
      FEEDBACK_INVERTER_EN <= 1'b0;
      STARTUP_TIMEOUT_FLAG <= 1'b0;
      FAST_INTERNAL_STABLE <= 1'b0;
      MEDIUM_INTERNAL_STABLE <= 1'b0;
      LOW_INTERNAL_STABLE <= 1'b0;
      SECONDARY_RUNNING <= 1'b0;
    end
    else
    begin
      if (sys_rise)
        quarter_cnt <= quarter_cnt + 2'h1;
      // quarter clock low and inverter off in sleep
      QUARTER_CLOCK_OUTPUT <= quarter_cnt[1] & (seq != SEQ_SLEEP);
      QUARTER_CLOCK_OE <= has_quarter_clock_output(PRIMARY_OSC_CONFIG);
      FEEDBACK_INVERTER_EN <= crystal & (seq != SEQ_SLEEP);
      STARTUP_TIMEOUT_FLAG <= startup_timeout_flag;
      FAST_INTERNAL_STABLE <= pin_lvl[PIN_FAST_RDY];
      MEDIUM_INTERNAL_STABLE <= pin_lvl[PIN_MED_RDY];
      LOW_INTERNAL_STABLE <= pin_lvl[PIN_LOW_RDY];
      SECONDARY_RUNNING <= (cur_src == SEL_SECONDARY) & ~busy;
    end
  end

  assign SYS_CLK_OUT = sys_clk;
  assign SWITCH_BUSY = busy;
  assign CLOCK_SOURCE_SELECT = csel;
  assign INTERNAL_FREQ_SELECT = freq_sel;
  assign MEDIUM_OSC_SELECT = med_sel;
  assign LOW_FREQ_SOURCE_SELECT = lf_sel;

endmodule : css_startup_ctrl
`default_nettype wire
